// >>> design/ccr_map.vh
// Contract
// - With background calibration off, core-select code picks the offline core; 3 reserved.
// - Averaging bits 6:4 hold offset averaging, reset 6, larger means more.
// - Averaging bits 2:0 hold linearity averaging, reset 1, larger means more.
// - Progress register is read-only; bits 4:2 report the calibration status code.
// - Stopped flag bit 1 sets on background halt, clears on resume.
// - With background calibration off, stopped sets when foreground finishes or skips.
// - Foreground-complete flag bit 0 sets when foreground finishes or is skipped.
// - Pin-setup bits 2:1 route complete, stopped, alarm or constant low to status pin.
// - Trigger-source bit 0 takes the software bit and ignores the trigger pin.
// - Trigger-source bit 1 takes the trigger pin and ignores the software bit.
// - Software trigger bit 0 resets to 1 and stands in for the pin level.
// - In trigger-controlled low-power mode a sleeping core wakes on low trigger.
`ifndef CCR_MAP_VH
`define CCR_MAP_VH

`define CCR_OFS_CORE_SEL     8'h64
`define CCR_OFS_AVERAGING    8'h68
`define CCR_OFS_PROGRESS     8'h6a
`define CCR_OFS_PIN_SETUP    8'h6b
`define CCR_OFS_SW_TRIGGER   8'h6c
`define CCR_OFS_LOW_POWER    8'h6e

`define CCR_RST_CORE_SEL     8'h02
`define CCR_RST_AVERAGING    8'h61
`define CCR_RST_PIN_SETUP    8'h00
`define CCR_RST_SW_TRIGGER   8'h01
`define CCR_RST_LOW_POWER    8'h88
`define CCR_RDATA_IDLE       8'h00

`define CCR_CORE_SEL_MSB     1
`define CCR_CORE_SEL_LSB     0
`define CCR_OFS_AVG_MSB      6
`define CCR_OFS_AVG_LSB      4
`define CCR_LIN_AVG_MSB      2
`define CCR_LIN_AVG_LSB      0
`define CCR_STOPPED_BIT      1
`define CCR_COMPLETE_BIT     0
`define CCR_PIN_SEL_MSB      2
`define CCR_PIN_SEL_LSB      1
`define CCR_TRIG_SRC_BIT     0
`define CCR_SW_TRIG_BIT      0
`define CCR_LP_SLEEP_MSB     7
`define CCR_LP_SLEEP_LSB     5
`define CCR_LP_WAKE_MSB      4
`define CCR_LP_WAKE_LSB      3
`define CCR_LP_TRIG_BIT      1
`define CCR_LP_EN_BIT        0

`define CCR_CORE_CODE_C0     2'h0
`define CCR_CORE_CODE_C1     2'h1
`define CCR_CORE_CODE_C2     2'h2
`define CCR_PIN_CODE_DONE    2'h0
`define CCR_PIN_CODE_STOP    2'h1
`define CCR_PIN_CODE_ALARM   2'h2

`define CCR_SYNC_STAGES      2

`endif

// >>> design/ccr_sync.v
`timescale 1ns/1ns
`default_nettype none
module ccr_sync #(
   parameter STAGES = 2
) (
   input  wire clk,
   input  wire rst_n,
   input  wire din,
   output wire dout
);

   reg [STAGES-1:0] chain_r;

   // The reset value is high so that an idle trigger does not look like a wake request.
   always @(posedge clk) begin
      if (!rst_n) begin
         chain_r <= {STAGES{1'b1}};
      end else begin
         chain_r <= {chain_r[STAGES-2:0], din};
      end
   end

   assign dout = chain_r[STAGES-1];

endmodule
`default_nettype wire

// >>> design/ccr_top.v
// Strobed register access was decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "ccr_map.vh"
module ccr_top #(
   parameter SYNC_STAGES = `CCR_SYNC_STAGES
) (
   input  wire       CLOCK,
   input  wire       RST_N,
   input  wire [7:0] ADDR,
   input  wire [7:0] WDATA,
   input  wire       WR,
   input  wire       RD,
   output wire [7:0] RDATA,
   input  wire       BG_CAL_EN,
   input  wire       FG_FINISH,
   input  wire       BG_HALTED,
   input  wire       BG_RESUMED,
   input  wire       CAL_RESTART,
   input  wire [2:0] STAT_CODE,
   input  wire       ALARM,
   input  wire       HARDWARE_TRIGGER_PIN,
   output wire [2:0] CORE_DISABLE,
   output wire       CORE1_SUBST,
   output wire [2:0] OFFSET_AVERAGING,
   output wire [2:0] LINEARITY_AVERAGING,
   output wire       STATUS_OUTPUT_PIN,
   output wire       CAL_TRIGGER,
   output wire       LP_ENABLE,
   output wire       LP_TRIG_MODE,
   output wire [2:0] LP_SLEEP_SEL,
   output wire [1:0] LP_WAKE_SEL,
   output wire       CORE_WAKE
);

   reg  [7:0] core_sel_r;
   reg  [7:0] avg_r;
   reg  [7:0] pin_setup_r;
   reg  [7:0] sw_trig_r;
   reg  [7:0] low_power_r;
   reg        complete_r;
   reg        stopped_r;
   reg  [2:0] stat_r;
   reg  [7:0] rdata_r;
   reg  [7:0] rdata_nxt;
   reg  [3:0] core_map_r;
   reg        status_pin_r;
   reg        status_pin_nxt;
   reg        trigger_r;
   reg        wake_r;
   wire       hw_trig_s;
   wire       trig_nxt;
   wire       complete_set;
   wire       stopped_set;
   wire       stopped_clr;

   // Returns {core1 substitutes, core2 off, core1 off, core0 off}.
   function [3:0] ccr_core_map;
      input [1:0] code;
      input       bg_on;
      begin
         ccr_core_map = 4'h0;
         if (!bg_on) begin
            case (code)
               `CCR_CORE_CODE_C0: ccr_core_map = 4'h9;
               `CCR_CORE_CODE_C1: ccr_core_map = 4'h2;
               `CCR_CORE_CODE_C2: ccr_core_map = 4'hc;
               default:           ccr_core_map = 4'h0;
            endcase
         end
      end
   endfunction

   function wr_hit;
      input       strobe;
      input [7:0] addr;
      input [7:0] offset;
      begin
         wr_hit = strobe && (addr == offset);
      end
   endfunction

   // Software register file; the progress register has no write path.
   always @(posedge CLOCK) begin
      if (!RST_N) begin
         core_sel_r  <= `CCR_RST_CORE_SEL;
         avg_r       <= `CCR_RST_AVERAGING;
         pin_setup_r <= `CCR_RST_PIN_SETUP;
         sw_trig_r   <= `CCR_RST_SW_TRIGGER;
         low_power_r <= `CCR_RST_LOW_POWER;
      end else begin
         if (wr_hit(WR, ADDR, `CCR_OFS_CORE_SEL)) begin
            core_sel_r <= WDATA;
         end
         if (wr_hit(WR, ADDR, `CCR_OFS_AVERAGING)) begin
            avg_r <= WDATA;
         end
         if (wr_hit(WR, ADDR, `CCR_OFS_PIN_SETUP)) begin
            pin_setup_r <= WDATA;
         end
         if (wr_hit(WR, ADDR, `CCR_OFS_SW_TRIGGER)) begin
            sw_trig_r <= WDATA;
         end
         if (wr_hit(WR, ADDR, `CCR_OFS_LOW_POWER)) begin
            low_power_r <= WDATA;
         end
      end
   end

   assign complete_set = FG_FINISH;
   // Without background calibration there is no phase to halt at, so the end of
   // foreground calibration is the stopping point.
   assign stopped_set  = BG_HALTED | (FG_FINISH & ~BG_CAL_EN);
   assign stopped_clr  = BG_RESUMED | CAL_RESTART;

   // A set arriving with a clear wins, so a finish is never lost.
   always @(posedge CLOCK) begin
      if (!RST_N) begin
         complete_r <= 1'b0;
         stopped_r  <= 1'b0;
         stat_r     <= 3'h0;
      end else begin
         if (complete_set) begin
            complete_r <= 1'b1;
         end else if (CAL_RESTART) begin
            complete_r <= 1'b0;
         end
         if (stopped_set) begin
            stopped_r <= 1'b1;
         end else if (stopped_clr) begin
            stopped_r <= 1'b0;
         end
         stat_r <= STAT_CODE;
      end
   end

   always @* begin
      rdata_nxt = `CCR_RDATA_IDLE;
      if (RD) begin
         case (ADDR)
            `CCR_OFS_CORE_SEL:   rdata_nxt = core_sel_r;
            `CCR_OFS_AVERAGING:  rdata_nxt = avg_r;
            `CCR_OFS_PROGRESS:   rdata_nxt = {3'h0, stat_r, stopped_r, complete_r};
            `CCR_OFS_PIN_SETUP:  rdata_nxt = pin_setup_r;
            `CCR_OFS_SW_TRIGGER: rdata_nxt = sw_trig_r;
            `CCR_OFS_LOW_POWER:  rdata_nxt = low_power_r;
            default:             rdata_nxt = `CCR_RDATA_IDLE;
         endcase
      end
   end

   always @* begin
      case (pin_setup_r[`CCR_PIN_SEL_MSB:`CCR_PIN_SEL_LSB])
         `CCR_PIN_CODE_DONE:  status_pin_nxt = complete_r;
         `CCR_PIN_CODE_STOP:  status_pin_nxt = stopped_r;
         `CCR_PIN_CODE_ALARM: status_pin_nxt = ALARM;
         default:             status_pin_nxt = 1'b0;
      endcase
   end

   ccr_sync #(
      .STAGES (SYNC_STAGES)
   ) u_trig_sync (
      .clk   (CLOCK),
      .rst_n (RST_N),
      .din   (HARDWARE_TRIGGER_PIN),
      .dout  (hw_trig_s)
   );

   // The pin path is a few cycles slower than the software path because of the synchroniser.
   assign trig_nxt = pin_setup_r[`CCR_TRIG_SRC_BIT] ? hw_trig_s
                                                    : sw_trig_r[`CCR_SW_TRIG_BIT];

   always @(posedge CLOCK) begin
      if (!RST_N) begin
         rdata_r      <= `CCR_RDATA_IDLE;
         core_map_r   <= 4'h0;
         status_pin_r <= 1'b0;
         trigger_r    <= 1'b1;
         wake_r       <= 1'b0;
      end else begin
         rdata_r      <= rdata_nxt;
         core_map_r   <= ccr_core_map(core_sel_r[`CCR_CORE_SEL_MSB:`CCR_CORE_SEL_LSB],
                                      BG_CAL_EN);
         status_pin_r <= status_pin_nxt;
         trigger_r    <= trig_nxt;
         wake_r       <= low_power_r[`CCR_LP_EN_BIT] & low_power_r[`CCR_LP_TRIG_BIT]
                         & ~trig_nxt;
      end
   end

   assign RDATA               = rdata_r;
   assign CORE_DISABLE        = core_map_r[2:0];
   assign CORE1_SUBST         = core_map_r[3];
   assign OFFSET_AVERAGING    = avg_r[`CCR_OFS_AVG_MSB:`CCR_OFS_AVG_LSB];
   assign LINEARITY_AVERAGING = avg_r[`CCR_LIN_AVG_MSB:`CCR_LIN_AVG_LSB];
   assign STATUS_OUTPUT_PIN   = status_pin_r;
   assign CAL_TRIGGER         = trigger_r;
   assign LP_ENABLE           = low_power_r[`CCR_LP_EN_BIT];
   assign LP_TRIG_MODE        = low_power_r[`CCR_LP_TRIG_BIT];
   assign LP_SLEEP_SEL        = low_power_r[`CCR_LP_SLEEP_MSB:`CCR_LP_SLEEP_LSB];
   assign LP_WAKE_SEL         = low_power_r[`CCR_LP_WAKE_MSB:`CCR_LP_WAKE_LSB];
   assign CORE_WAKE           = wake_r;

endmodule
`default_nettype wire

// >>> dv/ccr_properties.sv
`timescale 1ns/1ns
`default_nettype none
module ccr_properties #(
   parameter int SYNC_STAGES = 2
) (
   input wire logic       CLOCK,
   input wire logic       RST_N,
   input wire logic [7:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic       WR,
   input wire logic       RD,
   input wire logic [7:0] RDATA,
   input wire logic       BG_CAL_EN,
   input wire logic       FG_FINISH,
   input wire logic       BG_HALTED,
   input wire logic       BG_RESUMED,
   input wire logic       ALARM,
   input wire logic       HARDWARE_TRIGGER_PIN,
   input wire logic [2:0] CORE_DISABLE,
   input wire logic [2:0] OFFSET_AVERAGING,
   input wire logic [2:0] LINEARITY_AVERAGING,
   input wire logic       STATUS_OUTPUT_PIN,
   input wire logic       CAL_TRIGGER,
   input wire logic       CORE_WAKE
);
   localparam int DLY = SYNC_STAGES + 1;
   logic [1:0] cs_r;
   logic [2:0] ps_r;
   logic       sw_r;
   logic [1:0] lp_r;
   // Bus-side copies of the fields, so routing is judged from the ports alone.
   always_ff @(posedge CLOCK) begin
      if (!RST_N) begin
         cs_r <= 2'h2;
         ps_r <= 3'h0;
         sw_r <= 1'b1;
         lp_r <= 2'h0;
      end else if (WR) begin
         if (ADDR == 8'h64) cs_r <= WDATA[1:0];
         if (ADDR == 8'h6b) ps_r <= WDATA[2:0];
         if (ADDR == 8'h6c) sw_r <= WDATA[0];
         if (ADDR == 8'h6e) lp_r <= WDATA[1:0];
      end
   end
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!RST_N);
   sequence rd_prog;
      RD && ADDR == 8'h6a;
   endsequence
   AST_AVG: assert property (WR && ADDR == 8'h68 |=>
      {OFFSET_AVERAGING, LINEARITY_AVERAGING} == {$past(WDATA[6:4]), $past(WDATA[2:0])})
      else $error("averaging fields do not follow the write");
   AST_FG_SET: assert property (FG_FINISH && !BG_CAL_EN ##1 rd_prog |=>
      RDATA[1:0] == 2'h3) else $error("flags not set after foreground end");
   AST_HALT: assert property (BG_HALTED ##1 rd_prog |=> RDATA[1])
      else $error("stopped flag not set after halt");
   AST_RESUME: assert property (
      BG_RESUMED && !BG_HALTED && !FG_FINISH ##1 rd_prog |=> !RDATA[1])
      else $error("stopped flag not cleared on resume");
   AST_ALARM: assert property (ps_r[2:1] == 2'h2 |=>
      STATUS_OUTPUT_PIN == $past(ALARM)) else $error("status pin does not follow alarm");
   AST_LOW: assert property (ps_r[2:1] == 2'h3 |=> !STATUS_OUTPUT_PIN)
      else $error("status pin not held low");
   AST_SW_TRIG: assert property (!ps_r[0] |=> CAL_TRIGGER == $past(sw_r))
      else $error("trigger does not follow software bit");
   AST_HW_TRIG: assert property (ps_r[0] |=>
      CAL_TRIGGER == $past(HARDWARE_TRIGGER_PIN, DLY)) else $error("trigger not from pin");
   AST_CORE: assert property (1'b1 |=> CORE_DISABLE ==
      (($past(BG_CAL_EN) || $past(cs_r) == 2'h3) ? 3'h0 : 3'h1 << $past(cs_r)))
      else $error("offline core mismatch");
   AST_WAKE: assert property (1'b1 |=>
      CORE_WAKE == ($past(lp_r) == 2'h3 && !CAL_TRIGGER)) else $error("core wake mismatch");
   cover property (FG_FINISH && !BG_CAL_EN ##1 rd_prog);
   cover property (ps_r[2:1] == 2'h2 && ALARM);
   cover property (CORE_WAKE && ps_r[0]);
endmodule
bind ccr_top ccr_properties #(.SYNC_STAGES(SYNC_STAGES)) u_props (
   .CLOCK, .RST_N, .ADDR, .WDATA, .WR, .RD, .RDATA, .BG_CAL_EN, .FG_FINISH, .BG_HALTED,
   .BG_RESUMED, .ALARM, .HARDWARE_TRIGGER_PIN, .CORE_DISABLE, .OFFSET_AVERAGING,
   .LINEARITY_AVERAGING, .STATUS_OUTPUT_PIN, .CAL_TRIGGER, .CORE_WAKE
);
`default_nettype wire

// >>> dv/ccr_test.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin errors++; \
   $display("unexpected at %0t: got %h expected %h", $time, g, e); end end
module ccr_test;
   logic       CLOCK = 0, RST_N = 0, WR = 0, RD = 0, BG_CAL_EN = 0, ALARM = 0;
   logic       HARDWARE_TRIGGER_PIN = 1;
   logic [7:0] ADDR = 8'h00, WDATA = 8'h00;
   logic [2:0] STAT_CODE = 3'h0;
   logic [3:0] ev = 4'h0;
   wire  [7:0] RDATA;
   wire  [2:0] CORE_DISABLE, OFFSET_AVERAGING, LINEARITY_AVERAGING;
   wire        CORE1_SUBST, STATUS_OUTPUT_PIN, CAL_TRIGGER, CORE_WAKE;
   wire        LP_ENABLE, LP_TRIG_MODE;
   wire  [2:0] LP_SLEEP_SEL;
   wire  [1:0] LP_WAKE_SEL;
   int         errors = 0, cmp_count = 0, cyc = 0, seed = 32'hcec0_dbcf;
   logic [7:0] ra [6] = '{8'h64, 8'h68, 8'h6b, 8'h6c, 8'h6e, 8'h50};
   logic [7:0] rv [6] = '{8'h02, 8'h61, 8'h00, 8'h01, 8'h88, 8'h00};
   ccr_top #(.SYNC_STAGES(2)) dut (
      .CLOCK, .RST_N, .ADDR, .WDATA, .WR, .RD, .RDATA, .BG_CAL_EN, .ALARM, .STAT_CODE,
      .FG_FINISH(ev[0]), .BG_HALTED(ev[1]), .BG_RESUMED(ev[2]), .CAL_RESTART(ev[3]),
      .HARDWARE_TRIGGER_PIN, .CORE_DISABLE, .CORE1_SUBST, .OFFSET_AVERAGING, .CORE_WAKE,
      .LINEARITY_AVERAGING, .STATUS_OUTPUT_PIN, .CAL_TRIGGER, .LP_ENABLE,
      .LP_TRIG_MODE, .LP_SLEEP_SEL, .LP_WAKE_SEL
   );
   always #5 CLOCK = ~CLOCK;
   task end_sim;
      $display("errors %0d compares %0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   always @(posedge CLOCK) begin
      cyc++;
      if (cyc == 5000) begin
         errors++;
         end_sim();
      end
   end
   task tick(input int n);
      repeat (n) @(posedge CLOCK);
      #1;
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge CLOCK);
      WR <= 1'b1; ADDR <= a; WDATA <= d;
      tick(1);
      WR <= 1'b0;
   endtask
   // The strobe is dropped off the edge; the next request waits for a later edge.
   task rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge CLOCK);
      RD <= 1'b1; ADDR <= a; ev <= 4'h0;
      tick(1);
      RD <= 1'b0;
      `CHK(RDATA, e)
   endtask
   // The event stands one cycle; the read that follows drops it, so the read lands
   // in the very next cycle, as the checker's sequences expect.
   task pulse(input int k);
      @(posedge CLOCK);
      ev <= 4'h1 << k;
   endtask
   function automatic logic [2:0] off_exp(input logic [1:0] c, input logic bg);
      return (bg || c == 2'h3) ? 3'h0 : 3'h1 << c;
   endfunction
   initial begin
      logic [7:0] d;
      logic       t;
      int         i;
      repeat (5) @(posedge CLOCK);
      RST_N <= 1'b1;
      for (i = 0; i < 6; i++) rd(ra[i], rv[i]);
      rd(8'h6a, 8'h00);
      `CHK(LP_ENABLE, 1'b0)
      `CHK(LP_TRIG_MODE, 1'b0)
      `CHK(LP_SLEEP_SEL, 3'h4)
      `CHK(LP_WAKE_SEL, 2'h1)
      for (i = 0; i < 6; i++) begin
         d = $random(seed);
         wr(ra[i], d);
         wr(8'h6a, 8'hff);
         rd(ra[i], i == 5 ? 8'h00 : d);
         rd(8'h6a, 8'h00);
      end
      d = $random(seed);
      wr(8'h68, d);
      `CHK(OFFSET_AVERAGING, d[6:4])
      `CHK(LINEARITY_AVERAGING, d[2:0])
      for (i = 0; i < 8; i++) begin
         @(posedge CLOCK);
         BG_CAL_EN <= i[2];
         wr(8'h64, {6'h00, i[1:0]});
         tick(1);
         `CHK(CORE_DISABLE, off_exp(i[1:0], i[2]))
         `CHK(CORE1_SUBST, !i[2] && !i[0])
      end
      @(posedge CLOCK);
      BG_CAL_EN <= 1'b0;
      pulse(0); rd(8'h6a, 8'h03);
      pulse(3); rd(8'h6a, 8'h00);
      @(posedge CLOCK);
      BG_CAL_EN <= 1'b1;
      pulse(1); rd(8'h6a, 8'h02);
      pulse(2); rd(8'h6a, 8'h00);
      pulse(0); rd(8'h6a, 8'h01);
      for (i = 0; i < 4; i++) begin
         d = $random(seed);
         wr(8'h6b, {5'h00, i[1:0], 1'b0});
         @(posedge CLOCK);
         ALARM <= d[0];
         tick(2);
         `CHK(STATUS_OUTPUT_PIN, i == 2 ? d[0] : i == 0)
      end
      d = $random(seed);
      @(posedge CLOCK);
      STAT_CODE <= d[2:0];
      tick(1);
      rd(8'h6a, {3'h0, d[2:0], 2'h1});
      wr(8'h6e, 8'h03);
      `CHK(LP_ENABLE, 1'b1)
      `CHK(LP_TRIG_MODE, 1'b1)
      `CHK(LP_SLEEP_SEL, 3'h0)
      `CHK(LP_WAKE_SEL, 2'h0)
      for (i = 0; i < 8; i++) begin
         d = $random(seed);
         if (i == 4) wr(8'h6b, 8'h01);
         @(posedge CLOCK);
         HARDWARE_TRIGGER_PIN <= d[1];
         wr(8'h6c, {7'h00, d[0]});
         tick(4);
         t = i < 4 ? d[0] : d[1];
         `CHK(CAL_TRIGGER, t)
         `CHK(CORE_WAKE, !t)
      end
      wr(8'h6b, 8'h00);
      wr(8'h6c, 8'h01);
      tick(2);
      `CHK(CAL_TRIGGER, 1'b1)
      end_sim();
   end
endmodule
`default_nettype wire
